// ===== verilog/io_bus_pkg.sv
// constants and a helper function shared by both ends of the peripheral i/o bus
// assumes a single 20 MHz system clock on both ends
package io_bus_pkg;
	// ==========================================================
	// instruction and bus field widths
	localparam int DATA_W     = 16;
	localparam int CLASS_W    = 4;
	localparam int KFIELD_W   = 3;
	localparam int ORDER_W    = 3;
	localparam int DEV_W      = 6;
	localparam int ADDR_W     = 16;
	localparam logic [3:0] IO_CLASS_CODE = 4'hf;
	localparam logic [15:0] BRANCH_STEP  = 16'h0001;

	// ==========================================================
	// command classes on the k lines
	localparam logic [2:0] K_DEV_FUNC   = 3'h0;
	localparam logic [2:0] K_WORD_OUT   = 3'h1;
	localparam logic [2:0] K_WORD_IN    = 3'h2;
	localparam logic [2:0] K_STATUS_REQ = 3'h3;
	localparam logic [2:0] K_IRQ_POLL   = 3'h4;
	localparam logic [2:0] K_RES5       = 3'h5;
	localparam logic [2:0] K_RES6       = 3'h6;
	localparam logic [2:0] K_RES7       = 3'h7;

	// ==========================================================
	// timing
	localparam int CLK_NS          = 50;
	localparam int SETTLE_NS       = 100;
	localparam int SETTLE_CYC      = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int REJECT_NS       = 10000;
	localparam int REJECT_CYC      = REJECT_NS / CLK_NS;
	localparam int ECHO_CYC        = 2;
	localparam int TIMER_W         = 16;
	localparam logic [15:0] STATUS_RESET = 16'h0000;

	// returns 1 when the k code reads data back from the controller
	function automatic logic isInbound(input logic [2:0] k);
		return (k == K_WORD_IN) || (k == K_STATUS_REQ) ||
			(k == K_IRQ_POLL);
	endfunction
endpackage

// ===== verilog/io_bus_if.sv
// shared peripheral i/o bus joining the cpu end and one controller end
// data lines are open wiring: the bench resolves them from the enables
`timescale 1ns/100ps
interface io_bus_if;
	logic [2:0]  kLines;
	logic [2:0]  orderLines;
	logic [5:0]  devAddr;
	logic        strobe;
	logic        echoAck;
	logic [15:0] cpuDataOut;
	logic        cpuDataOe;
	logic [15:0] ctlDataOut;
	logic        ctlDataOe;
	logic [15:0] dataIn;

	modport cpu (
		output kLines, orderLines, devAddr, strobe, cpuDataOut, cpuDataOe,
		input  echoAck, dataIn
	);
	modport ctl (
		input  kLines, orderLines, devAddr, strobe, dataIn,
		output echoAck, ctlDataOut, ctlDataOe
	);
endinterface

// ===== verilog/io_cpu_end.sv
// cpu side of the peripheral i/o bus: command sequencer and reject timer
// assumes bus inputs come from another clock domain and are synchronised
// What this block does
// - class 15 instructions, or any high-rate command, become bus commands
// - order field passed through, never decoded
// - accumulator driven on data during device function
// - reject timer starts when strobe rises
// - reject stores pc at branch, fetches branch+1
// - drive fields, settle, then strobe with timer
// - controller latches command, then pulses echo
// - echo drops fields, data and strobe
// - word out uses device function sequence
// - word in: cpu stays off data lines
// - drive all 16 bits, capture whole bus
// - high-rate transfer uses memory, keeps cpu state
// - device function clears controller flags, status keeps
// - status request uses word in timing
// - poll answers on line set by POLL_LINE
// - poll leaves interrupt request pending
// - one controller on the bus at once
// - six-bit device code, only match responds
// - order lines read only when selected
// - class lines decoded only when selected
// - class codes 0..4 defined, 5 and 6 reserved
// - class 7 reserved, no action
// - echo captures word in data
`timescale 1ns/100ps
module io_cpu_end #(
	parameter int REJECT_CYCLES = io_bus_pkg::REJECT_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	io_bus_if.cpu            bus,
	input  wire logic        cmdValid,
	input  wire logic [15:0] instrWord,
	input  wire logic [15:0] branchAddr,
	input  wire logic        highRate,
	input  wire logic [15:0] accIn,
	input  wire logic [15:0] memDataIn,
	input  wire logic [15:0] pcIn,
	output logic             busy,
	output logic             done,
	output logic             rejected,
	output logic             notIo,
	output logic [15:0]      accOut,
	output logic             accWrite,
	output logic [15:0]      memDataOut,
	output logic             memWrite,
	output logic [15:0]      memAddr,
	output logic [15:0]      pcStoreData,
	output logic             pcStore,
	output logic [15:0]      fetchAddr,
	output logic             fetchRedirect
);
	typedef enum logic [1:0] {IDLE, SETTLE, STROBE, RELEASE} cpu_state_type;
	cpu_state_type state_q;

	logic [2:0]  kField;
	logic [2:0]  oField;
	logic [5:0]  dField;
	logic        isIo;
	logic        inbound_q;
	logic        highRate_q;
	logic [15:0] branch_q;
	logic [io_bus_pkg::TIMER_W-1:0] timer_q;
	logic [3:0]  settle_q;
	logic [2:0]  echoSync_q;
	logic [15:0] dataSync1_q;
	logic [15:0] dataSync2_q;
	logic        echoSeen;
	logic        timeout;

	assign isIo   = instrWord[15:12] == io_bus_pkg::IO_CLASS_CODE;
	assign kField = instrWord[11:9];
	assign oField = instrWord[8:6];
	assign dField = instrWord[5:0];
	// echo counted once second and third stages agree high
	assign echoSeen = echoSync_q[1] & echoSync_q[2];
	assign timeout  = timer_q >= io_bus_pkg::TIMER_W'(REJECT_CYCLES - 1);
	assign busy     = state_q != IDLE;

	// ==========================================================
	// synchronisers for echo and returning data
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			echoSync_q  <= 3'h0;
			dataSync1_q <= 16'h0000;
			dataSync2_q <= 16'h0000;
		end else begin
			echoSync_q  <= {echoSync_q[1:0], bus.echoAck};
			dataSync1_q <= bus.dataIn;
			dataSync2_q <= dataSync1_q;
		end
	end

	// ==========================================================
	// command sequencer
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= IDLE;
		end else begin
			unique case (state_q)
				IDLE: begin
					if (cmdValid && (isIo || highRate)) begin
						state_q <= SETTLE;
					end
				end
				SETTLE: begin
					if (settle_q == 4'(io_bus_pkg::SETTLE_CYC - 1)) begin
						state_q <= STROBE;
					end
				end
				STROBE: begin
					if (echoSeen || timeout) begin
						state_q <= RELEASE;
					end
				end
				RELEASE: begin
					// wait for echo to fall so one echo ends one command
					if (!echoSync_q[2]) begin
						state_q <= IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			settle_q <= 4'h0;
		end else if (state_q == SETTLE) begin
			settle_q <= settle_q + 4'h1;
		end else begin
			settle_q <= 4'h0;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			timer_q <= '0;
		end else if (state_q == STROBE) begin
			timer_q <= timer_q + 1'b1;
		end else begin
			timer_q <= '0;
		end
	end

	// ==========================================================
	// bus drivers, held from issue until echo or reject
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			bus.kLines     <= 3'h0;
			bus.orderLines <= 3'h0;
			bus.devAddr    <= 6'h00;
			bus.cpuDataOut <= 16'h0000;
			bus.cpuDataOe  <= 1'b0;
			inbound_q      <= 1'b0;
			highRate_q     <= 1'b0;
			branch_q       <= 16'h0000;
		end else if (state_q == IDLE && cmdValid && (isIo || highRate)) begin
			bus.kLines     <= kField;
			bus.orderLines <= oField;
			bus.devAddr    <= dField;
			// high-rate words come from memory, not the accumulator
			bus.cpuDataOut <= highRate ? memDataIn : accIn;
			bus.cpuDataOe  <= !io_bus_pkg::isInbound(kField);
			inbound_q      <= io_bus_pkg::isInbound(kField);
			highRate_q     <= highRate;
			branch_q       <= branchAddr;
		end else if (state_q == STROBE && (echoSeen || timeout)) begin
			bus.kLines     <= 3'h0;
			bus.orderLines <= 3'h0;
			bus.devAddr    <= 6'h00;
			bus.cpuDataOut <= 16'h0000;
			bus.cpuDataOe  <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			bus.strobe <= 1'b0;
		end else begin
			bus.strobe <= (state_q == SETTLE &&
				settle_q == 4'(io_bus_pkg::SETTLE_CYC - 1)) ||
				(state_q == STROBE && !echoSeen && !timeout);
		end
	end

	// ==========================================================
	// completion, capture and reject branch
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			done          <= 1'b0;
			rejected      <= 1'b0;
			notIo         <= 1'b0;
			accOut        <= 16'h0000;
			accWrite      <= 1'b0;
			memDataOut    <= 16'h0000;
			memWrite      <= 1'b0;
			memAddr       <= 16'h0000;
			pcStoreData   <= 16'h0000;
			pcStore       <= 1'b0;
			fetchAddr     <= 16'h0000;
			fetchRedirect <= 1'b0;
		end else begin
			done          <= 1'b0;
			rejected      <= 1'b0;
			accWrite      <= 1'b0;
			memWrite      <= 1'b0;
			pcStore       <= 1'b0;
			fetchRedirect <= 1'b0;
			notIo         <= state_q == IDLE && cmdValid && !isIo &&
				!highRate;
			if (state_q == STROBE && echoSeen) begin
				done <= 1'b1;
				if (inbound_q && !highRate_q) begin
					accOut   <= dataSync2_q;
					accWrite <= 1'b1;
				end
				if (inbound_q && highRate_q) begin
					memDataOut <= dataSync2_q;
					memWrite   <= 1'b1;
				end
			end else if (state_q == STROBE && timeout) begin
				done     <= 1'b1;
				rejected <= 1'b1;
				// high-rate sequences leave cpu control state alone
				if (!highRate_q) begin
					memAddr       <= branch_q;
					pcStoreData   <= pcIn;
					pcStore       <= 1'b1;
					fetchAddr     <= branch_q + io_bus_pkg::BRANCH_STEP;
					fetchRedirect <= 1'b1;
				end
			end
		end
	end
endmodule

// ===== verilog/io_ctl_end.sv
// peripheral controller end of the i/o bus: select, latch, echo
// assumes strobe and fields arrive from the cpu clock domain
`timescale 1ns/100ps
module io_ctl_end #(
	parameter logic [5:0] DEV_CODE  = 6'h10,
	parameter logic [3:0] POLL_LINE = 4'h0
) (
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	io_bus_if.ctl            bus,
	input  wire logic [15:0] txWord,
	input  wire logic [15:0] statusIn,
	input  wire logic        statusSet,
	input  wire logic        irqRequest,
	output logic [2:0]       cmdClass,
	output logic [2:0]       cmdOrder,
	output logic [15:0]      cmdData,
	output logic             cmdPulse,
	output logic [15:0]      statusFlags,
	output logic             irqOut
);
	typedef enum logic [1:0] {WAIT, DRIVE, ECHO, DROP} ctl_state_type;
	ctl_state_type state_q;

	logic [2:0]  strobeSync_q;
	logic        strobeSeen;
	logic        selected;
	logic        validClass;
	logic [1:0]  echoCnt_q;
	logic [15:0] answer;

	assign strobeSeen = strobeSync_q[1] & strobeSync_q[2];
	assign selected   = strobeSeen && bus.devAddr == DEV_CODE;
	assign validClass = bus.kLines <= io_bus_pkg::K_IRQ_POLL;
	assign irqOut     = irqRequest;

	always_comb begin
		unique case (bus.kLines)
			io_bus_pkg::K_STATUS_REQ: answer = statusFlags;
			io_bus_pkg::K_IRQ_POLL:   answer = 16'(irqRequest) << POLL_LINE;
			default:                  answer = txWord;
		endcase
	end

	// ==========================================================
	// strobe synchroniser
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			strobeSync_q <= 3'h0;
		end else begin
			strobeSync_q <= {strobeSync_q[1:0], bus.strobe};
		end
	end

	// ==========================================================
	// handshake: data settles a cycle before echo, held through it
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_q   <= WAIT;
			echoCnt_q <= 2'h0;
		end else begin
			unique case (state_q)
				WAIT: begin
					if (selected && validClass) begin
						state_q <= DRIVE;
					end
				end
				DRIVE: begin
					state_q <= ECHO;
				end
				ECHO: begin
					echoCnt_q <= echoCnt_q + 2'h1;
					if (echoCnt_q == 2'(io_bus_pkg::ECHO_CYC - 1)) begin
						state_q   <= DROP;
						echoCnt_q <= 2'h0;
					end
				end
				DROP: begin
					// no new command until the cpu has let strobe fall
					if (!strobeSync_q[2]) begin
						state_q <= WAIT;
					end
				end
			endcase
		end
	end

	assign bus.echoAck = state_q == ECHO;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			bus.ctlDataOut <= 16'h0000;
			bus.ctlDataOe  <= 1'b0;
		end else if (state_q == WAIT && selected && validClass &&
			io_bus_pkg::isInbound(bus.kLines)) begin
			bus.ctlDataOut <= answer;
			bus.ctlDataOe  <= 1'b1;
		end else if (state_q == DROP || state_q == WAIT) begin
			bus.ctlDataOut <= 16'h0000;
			bus.ctlDataOe  <= 1'b0;
		end
	end

	// ==========================================================
	// command latch and status flags
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cmdClass <= 3'h0;
			cmdOrder <= 3'h0;
			cmdData  <= 16'h0000;
			cmdPulse <= 1'b0;
		end else begin
			cmdPulse <= 1'b0;
			if (state_q == WAIT && selected && validClass) begin
				cmdClass <= bus.kLines;
				cmdOrder <= bus.orderLines;
				cmdData  <= bus.dataIn;
				cmdPulse <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			statusFlags <= io_bus_pkg::STATUS_RESET;
		end else if (statusSet) begin
			// new device event wins over a clear in the same cycle
			statusFlags <= statusFlags | statusIn;
		end else if (state_q == WAIT && selected &&
			bus.kLines == io_bus_pkg::K_DEV_FUNC) begin
			statusFlags <= io_bus_pkg::STATUS_RESET;
		end
	end
endmodule

// ===== verif/io_bus_command_handshake_sva.sv
// assertions on the i/o bus signals joining cpu end and controller end
// assumes one clock for both ends, signals taken from the interface
`timescale 1ns/100ps
module io_bus_command_handshake_sva #(
	parameter int         REJECT_CYCLES = 40,
	parameter logic [5:0] DEV_CODE      = 6'h2a
) (
	input wire logic       clk_sys,
	input wire logic       arst_n,
	input wire logic [2:0] kLines,
	input wire logic [2:0] orderLines,
	input wire logic [5:0] devAddr,
	input wire logic       strobe,
	input wire logic       echoAck,
	input wire logic       cpuDataOe,
	input wire logic       ctlDataOe
);
	// ==========================================================
	// sequences
	localparam int STROBE_MAX = REJECT_CYCLES + 4;
	logic inbound;
	assign inbound = kLines inside {io_bus_pkg::K_WORD_IN,
		io_bus_pkg::K_STATUS_REQ, io_bus_pkg::K_IRQ_POLL};
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	sequence strobeStart; $rose(strobe); endsequence
	sequence echoStart; $rose(echoAck); endsequence
	sequence inEcho; echoStart ##0 inbound; endsequence
	// ==========================================================
	// assertions
	settle_first_a:
		assert property (strobeStart |-> $past({kLines, orderLines,
			devAddr}, 2) == {kLines, orderLines, devAddr})
		else $error("strobe rose before fields settled");
	fields_hold_a:
		assert property (strobe && $past(strobe) |->
			$stable({kLines, orderLines, devAddr}))
		else $error("fields moved under strobe");
	echo_drop_a:
		assert property (echoStart |-> ##[1:6] !strobe)
		else $error("strobe kept after echo");
	fields_release_a:
		assert property ($fell(strobe) |-> kLines == 3'h0 &&
			devAddr == 6'h00 && !cpuDataOe)
		else $error("fields not released with strobe");
	out_data_a:
		assert property (strobe && kLines <= io_bus_pkg::K_WORD_OUT |->
			cpuDataOe)
		else $error("accumulator not driven on output command");
	in_quiet_a:
		assert property (strobe && inbound |-> !cpuDataOe)
		else $error("cpu drives data on inbound command");
	in_hold_a:
		assert property (inEcho |-> $past(ctlDataOe) && ctlDataOe
			##1 ctlDataOe)
		else $error("controller data not held around echo");
	one_driver_a:
		assert property (!(cpuDataOe && ctlDataOe))
		else $error("two drivers on data lines");
	echo_select_a:
		assert property (echoStart |-> strobe && devAddr == DEV_CODE &&
			kLines <= io_bus_pkg::K_IRQ_POLL)
		else $error("echo without valid selection");
	echo_len_a:
		assert property (echoStart |-> echoAck ##1 echoAck ##1 !echoAck)
		else $error("echo pulse length wrong");
	reject_bound_a:
		assert property (strobeStart |-> ##[1:STROBE_MAX] !strobe)
		else $error("strobe outlived reject timer");
endmodule

// ===== verif/io_bus_command_handshake_test.sv
// self-checking bench: cpu end and controller end joined by the bus
// assumes package, interface and both ends are compiled first
`timescale 1ns/100ps
module io_bus_command_handshake_test;
	// ==========================================================
	// signals
	typedef struct {
		logic [2:0]  k;
		logic [2:0]  ord;
		logic [5:0]  dev;
		logic        hr;
		logic        rej;
		logic [15:0] acc;
		logic [15:0] exp;
	} row_type;
	logic        clk_sys = 1'b0;
	logic        arst_n = 1'b0;
	logic        cmdValid = 1'b0;
	logic [15:0] instrWord = 16'h0000;
	logic        highRate = 1'b0;
	logic [15:0] accIn = 16'h0000;
	logic [15:0] memDataIn = 16'h0000;
	logic [15:0] statusIn = 16'h0c30;
	logic        statusSet = 1'b0;
	logic        irqRequest = 1'b1;
	logic [15:0] branchAddr = 16'h0300;
	logic [15:0] pcIn = 16'h0123;
	logic [15:0] txWord = 16'hbeef;
	logic        busy, done, rejected, notIo, accWrite, memWrite, pcStore;
	logic        fetchRedirect, cmdPulse, irqOut;
	logic [15:0] accOut, memDataOut, memAddr, pcStoreData, fetchAddr;
	logic [2:0]  cmdClass, cmdOrder;
	logic [15:0] cmdData, statusFlags, flags;
	int          badCount = 0;
	int          checks = 0;
	int          cycles = 0;
	row_type     rows [13];
	io_bus_if io_bus_if_inst ();
	// open wiring: whichever end enables drives the data lines
	assign io_bus_if_inst.dataIn =
		(io_bus_if_inst.cpuDataOe ? io_bus_if_inst.cpuDataOut : 16'h0000) |
		(io_bus_if_inst.ctlDataOe ? io_bus_if_inst.ctlDataOut : 16'h0000);
	io_cpu_end #(.REJECT_CYCLES(40)) io_cpu_end_inst (
		.clk_sys(clk_sys), .arst_n(arst_n), .bus(io_bus_if_inst),
		.cmdValid(cmdValid), .instrWord(instrWord),
		.branchAddr(branchAddr), .highRate(highRate), .accIn(accIn),
		.memDataIn(memDataIn), .pcIn(pcIn), .busy(busy), .done(done),
		.rejected(rejected), .notIo(notIo), .accOut(accOut),
		.accWrite(accWrite), .memDataOut(memDataOut),
		.memWrite(memWrite), .memAddr(memAddr),
		.pcStoreData(pcStoreData), .pcStore(pcStore),
		.fetchAddr(fetchAddr), .fetchRedirect(fetchRedirect));
	io_ctl_end #(.DEV_CODE(6'h2a), .POLL_LINE(4'h5)) io_ctl_end_inst (
		.clk_sys(clk_sys), .arst_n(arst_n), .bus(io_bus_if_inst),
		.txWord(txWord), .statusIn(statusIn), .statusSet(statusSet),
		.irqRequest(irqRequest), .cmdClass(cmdClass),
		.cmdOrder(cmdOrder), .cmdData(cmdData), .cmdPulse(cmdPulse),
		.statusFlags(statusFlags), .irqOut(irqOut));
	io_bus_command_handshake_sva #(.REJECT_CYCLES(40), .DEV_CODE(6'h2a))
		io_bus_command_handshake_sva_inst (
		.clk_sys(clk_sys), .arst_n(arst_n),
		.kLines(io_bus_if_inst.kLines),
		.orderLines(io_bus_if_inst.orderLines),
		.devAddr(io_bus_if_inst.devAddr), .strobe(io_bus_if_inst.strobe),
		.echoAck(io_bus_if_inst.echoAck),
		.cpuDataOe(io_bus_if_inst.cpuDataOe),
		.ctlDataOe(io_bus_if_inst.ctlDataOe));
	// ==========================================================
	// tasks
	always #25 clk_sys = ~clk_sys;
	task automatic check(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			badCount++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, badCount);
		if (badCount == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic issue(input logic [15:0] iw, input logic hr,
		input logic [15:0] acc);
		@(posedge clk_sys);
		cmdValid <= 1'b1;
		instrWord <= iw;
		highRate <= hr;
		accIn <= acc;
		memDataIn <= ~acc;
		@(posedge clk_sys);
		cmdValid <= 1'b0;
	endtask
	task automatic runRow(input row_type r);
		logic gotAcc, gotMem, gotPc, gotCmd, gotRej, gotFr, inb;
		{gotAcc, gotMem, gotPc, gotCmd, gotRej, gotFr} = 6'h00;
		inb = r.k inside {3'h2, 3'h3, 3'h4};
		issue({io_bus_pkg::IO_CLASS_CODE, r.k, r.ord, r.dev}, r.hr, r.acc);
		// pulses are gathered across the whole transfer
		do begin
			@(negedge clk_sys);
			gotAcc |= accWrite;
			gotMem |= memWrite;
			gotPc |= pcStore;
			gotCmd |= cmdPulse;
			gotRej |= rejected;
			gotFr |= fetchRedirect;
		end while (done !== 1'b1);
		while (busy === 1'b1) @(negedge clk_sys);
		check("rejected", 16'(gotRej), 16'(r.rej));
		check("accWrite", 16'(gotAcc), 16'(inb && !r.rej && !r.hr));
		check("memWrite", 16'(gotMem), 16'(inb && !r.rej && r.hr));
		check("pcStore", 16'(gotPc), 16'(r.rej && !r.hr));
		check("fetchRedirect", 16'(gotFr), 16'(r.rej && !r.hr));
		check("cmdPulse", 16'(gotCmd), 16'(!r.rej));
		if (!r.rej) begin
			check("cmdClass", 16'(cmdClass), 16'(r.k));
			check("cmdOrder", 16'(cmdOrder), 16'(r.ord));
			if (inb)
				check("dataIn", r.hr ? memDataOut : accOut, r.exp);
			else
				check("cmdData", cmdData, r.exp);
		end
		if (gotPc) begin
			check("pcStoreData", pcStoreData, pcIn);
			check("memAddr", memAddr, branchAddr);
			check("fetchAddr", fetchAddr, branchAddr + 16'h0001);
		end
		if (!r.rej && r.k == io_bus_pkg::K_DEV_FUNC) flags = 16'h0000;
		check("statusFlags", statusFlags, flags);
		check("irqOut", 16'(irqOut), 16'(irqRequest));
	endtask
	// ==========================================================
	// sequence of tests
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			badCount++;
			end_of_test();
		end
	end
	initial begin
		rows = '{'{3'h1, 3'h2, 6'h2a, 0, 0, 16'h1234, 16'h1234},
			'{3'h2, 3'h7, 6'h2a, 0, 0, 16'h5555, 16'hbeef},
			'{3'h3, 3'h1, 6'h2a, 0, 0, 16'h0000, 16'h0c30},
			'{3'h4, 3'h0, 6'h2a, 0, 0, 16'h0000, 16'h0020},
			'{3'h0, 3'h5, 6'h2a, 0, 0, 16'ha5c3, 16'ha5c3},
			'{3'h1, 3'h0, 6'h2b, 0, 1, 16'h0000, 16'h0000},
			'{3'h0, 3'h0, 6'h3f, 0, 1, 16'h0000, 16'h0000},
			'{3'h5, 3'h0, 6'h2a, 0, 1, 16'h0000, 16'h0000},
			'{3'h6, 3'h0, 6'h2a, 0, 1, 16'h0000, 16'h0000},
			'{3'h7, 3'h0, 6'h2a, 0, 1, 16'h0000, 16'h0000},
			'{3'h1, 3'h4, 6'h2a, 1, 0, 16'h00ff, 16'hff00},
			'{3'h2, 3'h6, 6'h2a, 1, 0, 16'h0000, 16'hbeef},
			'{3'h2, 3'h0, 6'h00, 1, 1, 16'h0000, 16'h0000}};
		repeat (2) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(negedge clk_sys);
		check("busy", 16'(busy), 16'h0000);
		check("strobe", 16'(io_bus_if_inst.strobe), 16'h0000);
		@(posedge clk_sys);
		statusSet <= 1'b1;
		@(posedge clk_sys);
		statusSet <= 1'b0;
		flags = 16'h0c30;
		foreach (rows[i]) runRow(rows[i]);
		// a class other than the i/o class, without high-rate, must never reach the bus
		issue({4'he, 3'h1, 3'h0, 6'h2a}, 1'b0, 16'h0000);
		@(negedge clk_sys);
		check("notIo", 16'(notIo), 16'h0001);
		repeat (8) @(negedge clk_sys);
		check("strobe", 16'(io_bus_if_inst.strobe), 16'h0000);
		// device event held across the clear edge must survive it
		@(posedge clk_sys);
		statusIn <= 16'h0003;
		statusSet <= 1'b1;
		issue({io_bus_pkg::IO_CLASS_CODE, io_bus_pkg::K_DEV_FUNC, 3'h0,
			6'h2a}, 1'b0, 16'h0000);
		do begin
			@(negedge clk_sys);
		end while (cmdPulse !== 1'b1);
		check("setWins", statusFlags, 16'h0003);
		@(posedge clk_sys);
		statusSet <= 1'b0;
		while (busy === 1'b1) @(negedge clk_sys);
		flags = 16'h0003;
		// poll with no request pending answers with an empty word
		@(posedge clk_sys);
		irqRequest <= 1'b0;
		rows[3].exp = 16'h0000;
		runRow(rows[3]);
		// reset in the middle of a strobe, then a clean command
		issue({io_bus_pkg::IO_CLASS_CODE, io_bus_pkg::K_WORD_OUT, 3'h0,
			6'h2a}, 1'b0, 16'h1111);
		while (io_bus_if_inst.strobe !== 1'b1) @(negedge clk_sys);
		@(posedge clk_sys);
		arst_n <= 1'b0;
		@(negedge clk_sys);
		check("rstBusy", 16'(busy), 16'h0000);
		check("rstStrobe", 16'(io_bus_if_inst.strobe), 16'h0000);
		check("rstFlags", statusFlags, 16'h0000);
		repeat (2) @(posedge clk_sys);
		arst_n <= 1'b1;
		flags = 16'h0000;
		runRow(rows[0]);
		end_of_test();
	end
endmodule
